// ---- design/datc_pkg.sv ----
// Shared constants and types for the DRAM access timing block.
// Assumes a single 250 MHz clock where two clocks make one bus cycle.
package datc_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0] ADDR_DMA_WAIT = 8'h00;
	localparam logic [7:0] ADDR_DRAM_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// Reset values and writable-bit masks
	localparam logic [15:0] RST_DMA_WAIT = 16'h000f;
	localparam logic [15:0] RST_DRAM_CTRL = 16'h0000;
	localparam logic [15:0] MASK_DMA_WAIT = 16'h003f;
	localparam logic [15:0] MASK_DRAM_CTRL = 16'hffbf;

	// Field positions, dma_single_address_wait
	localparam int POS_DMA_DRAM_WAIT = 4;
	localparam int POS_DMA_CS_WAIT = 0;

	// Field positions, dram_area_control
	localparam int POS_PRECHARGE = 15;
	localparam int POS_ROW_TO_COL = 14;
	localparam int POS_REFRESH_LEN = 12;
	localparam int POS_WRITE_WAIT = 10;
	localparam int POS_READ_WAIT = 8;
	localparam int POS_IDLE_INSERT = 7;
	localparam int POS_BURST_PAGE = 5;
	localparam int POS_ROW_HOLD = 4;
	localparam int POS_WIDTH = 2;
	localparam int POS_ADDR_MUX = 0;

	// Phase lengths in clocks; one clock is half a bus cycle
	localparam int CNT_W = 6;
	localparam logic [5:0] PRECHG_HALF = 6'h03;
	localparam logic [5:0] ROW_HALF = 6'h02;
	localparam logic [5:0] COL_HALF = 6'h04;
	localparam logic [5:0] REFRESH_ENABLE_HALF = 6'h05;
	localparam logic [5:0] CS_HALF = 6'h04;
	localparam logic [5:0] GAP_HALF = 6'h02;
	localparam logic [5:0] CBR_LEAD_HALF = 6'h02;

	// Row shift and bus width encodings
	localparam logic [3:0] ROW_SHIFT_BASE = 4'h9;
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ROW, ST_COL, ST_CS, ST_GAP, ST_PRECHG, ST_CBR_CAS, ST_CBR_RAS
	} datc_state_t;

	typedef struct packed {
		logic write;
		logic dma;
		logic cs_space;
		logic [31:0] addr;
	} datc_req_t;

	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cs_n;
		logic [15:0] addr;
	} datc_pins_t;

endpackage

// ---- design/datc_sync3.sv ----
// Three-stage synchroniser for a pin input.
// Assumes the input is asynchronous; output moves once stages two and three agree.
`timescale 1ns/1ps
module datc_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic d,
	output logic q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Filters a single-clock disagreement during metastable settling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= RST_VAL;
		end else if (s2_q == s3_q) begin
			out_q <= s3_q;
		end
	end

	assign q = out_q;
endmodule

// ---- design/datc_phase_timer.sv ----
// Down counter timing one bus phase, with optional external wait stretch.
// Assumes the caller loads it on the clock that enters the phase.
`timescale 1ns/1ps
module datc_phase_timer #(
	parameter int CNT_W = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic load,
	input wire logic [CNT_W-1:0] load_val,
	input wire logic wait_en,
	input wire logic wait_act,
	// Status
	output logic last
);
	logic [CNT_W-1:0] cnt_q;

	// Holding on the final count stretches the phase while wait is asserted
	assign last = (cnt_q == CNT_W'(1)) && !(wait_en && wait_act);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q > CNT_W'(1) || last) begin
			cnt_q <= cnt_q - CNT_W'(1);
		end
	end
endmodule

// ---- design/datc_top.sv ----
// DRAM access timing and configuration: APB registers plus access sequencer.
// Assumes requests and refresh matches come from logic on the same clock;
// only the external wait pin is asynchronous. One bus cycle is two clocks.
`timescale 1ns/1ps

// How it works
// - DMA DRAM code gives 2 to 5 cycles; wait pin on upper two.
// - DMA DRAM accesses ignore the read and write column codes.
// - DMA chip-select wait gives 0 to 15 waits; nonzero enables wait pin.
// - Reset: chip-select wait fifteen, DMA DRAM wait two cycles.
// - DMA chip-select wait ignores per-area wait.
// - Wait register bits 15 to 6 read zero.
// - Control register clears only on power-on reset.
// - Precharge bit gives 1.5 or 2.5 cycles minimum between RAS pulses, except one cycle across an idle insert with the row held open.
// - Row address stands one or two cycles before column phase.
// - Refresh RAS low 2.5 to 5.5 cycles by code.
// - Write column lasts 2 to 5 cycles; wait pin on upper two.
// - Read column lasts 2 to 5 cycles; wait pin on upper two.
// - Idle insert adds a cycle after DRAM read before write or chip-select.
// - Page mode reuses the open row.
// - Row hold bit selects RAS up or down mode.
// - Width code gives 8, 16 or 32 bits; upper bit forces 32.
// - Multiplex code shifts the row address 9 to 12 bits.
// - Control bit 6 reads zero, ignores writes.
// - Refresh match starts CBR refresh when enabled, not self-refresh.
module datc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Access requests
	input wire logic req_valid,
	input wire datc_pkg::datc_req_t req,
	input wire logic [3:0] cs_area_wait,
	output logic acc_done,
	// Refresh control from the refresh timer
	input wire logic refresh_match,
	input wire logic refresh_enable,
	input wire logic refresh_kind_select,
	// External memory pins
	input wire logic ext_wait_n,
	output datc_pkg::datc_pins_t dram_pins,
	// Decoded configuration
	output logic [1:0] bus_width,
	output logic [3:0] row_shift
);
	logic rst_meta_q;
	logic rst_n_q;

	// Only reset in this block is power-on; manual reset is not wired here
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// APB
	logic setup;
	logic access;
	logic wr_dma_wait;
	logic wr_dram_ctrl;
	logic addr_hit;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [15:0] dma_wait_q;
	logic [15:0] dram_ctrl_q;
	logic [15:0] status;

	assign setup = psel && !penable;
	assign access = psel && penable && pready_q;
	assign wr_dma_wait = access && pwrite && (paddr == datc_pkg::ADDR_DMA_WAIT);
	assign wr_dram_ctrl = access && pwrite && (paddr == datc_pkg::ADDR_DRAM_CTRL);
	assign addr_hit = (paddr == datc_pkg::ADDR_DMA_WAIT) ||
		(paddr == datc_pkg::ADDR_DRAM_CTRL) || (paddr == datc_pkg::ADDR_STATUS);

	// Ready registered from setup, no wait state; keeps the read mux off the pready path
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= setup && !addr_hit;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			case (paddr)
				datc_pkg::ADDR_DMA_WAIT: prdata_q <= {16'h0000, dma_wait_q};
				datc_pkg::ADDR_DRAM_CTRL: prdata_q <= {16'h0000, dram_ctrl_q};
				datc_pkg::ADDR_STATUS: prdata_q <= {16'h0000, status};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dma_wait_q <= datc_pkg::RST_DMA_WAIT;
		end else if (wr_dma_wait) begin
			dma_wait_q <= pwdata[15:0] & datc_pkg::MASK_DMA_WAIT;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dram_ctrl_q <= datc_pkg::RST_DRAM_CTRL;
		end else if (wr_dram_ctrl) begin
			dram_ctrl_q <= pwdata[15:0] & datc_pkg::MASK_DRAM_CTRL;
		end
	end

	// Configuration fields
	logic [1:0] dma_dram_wait;
	logic [3:0] dma_cs_wait;
	logic precharge_length;
	logic row_to_column_delay;
	logic [1:0] refresh_assert_len;
	logic [1:0] write_column_wait;
	logic [1:0] read_column_wait;
	logic idle_insert;
	logic burst_page_enable;
	logic row_strobe_hold;
	logic [1:0] dram_width;
	logic [1:0] addr_multiplex;

	assign dma_dram_wait = dma_wait_q[datc_pkg::POS_DMA_DRAM_WAIT +: 2];
	assign dma_cs_wait = dma_wait_q[datc_pkg::POS_DMA_CS_WAIT +: 4];
	assign precharge_length = dram_ctrl_q[datc_pkg::POS_PRECHARGE];
	assign row_to_column_delay = dram_ctrl_q[datc_pkg::POS_ROW_TO_COL];
	assign refresh_assert_len = dram_ctrl_q[datc_pkg::POS_REFRESH_LEN +: 2];
	assign write_column_wait = dram_ctrl_q[datc_pkg::POS_WRITE_WAIT +: 2];
	assign read_column_wait = dram_ctrl_q[datc_pkg::POS_READ_WAIT +: 2];
	assign idle_insert = dram_ctrl_q[datc_pkg::POS_IDLE_INSERT];
	assign burst_page_enable = dram_ctrl_q[datc_pkg::POS_BURST_PAGE];
	assign row_strobe_hold = dram_ctrl_q[datc_pkg::POS_ROW_HOLD];
	assign dram_width = dram_ctrl_q[datc_pkg::POS_WIDTH +: 2];
	assign addr_multiplex = dram_ctrl_q[datc_pkg::POS_ADDR_MUX +: 2];

	// Sequencer
	datc_pkg::datc_state_t state_q;
	datc_pkg::datc_state_t state_d;
	datc_pkg::datc_req_t cur_q;
	datc_pkg::datc_req_t dreq;
	datc_pkg::datc_pins_t pins_q;
	logic [31:0] open_row_q;
	logic [31:0] dreq_row;
	logic [3:0] shift_q;
	logic [1:0] width_q;
	logic row_open_q;
	logic row_open_d;
	logic gap_armed_q;
	logic refresh_enable_pend_q;
	logic acc_done_q;
	logic wait_en_q;
	logic wait_en_d;
	logic wait_pin;
	logic tmr_load;
	logic tmr_last;
	logic take;
	logic same_row;
	logic keep_row;
	logic [1:0] col_code;
	logic [3:0] cs_wait;
	localparam int CNT_W_TOP = datc_pkg::CNT_W;
	logic [CNT_W_TOP-1:0] tmr_val;
	logic [CNT_W_TOP-1:0] col_len;
	logic [CNT_W_TOP-1:0] cs_len;
	logic [CNT_W_TOP-1:0] row_len;
	logic [CNT_W_TOP-1:0] prechg_len;
	logic [CNT_W_TOP-1:0] refresh_enable_len;

	datc_sync3 #(
		.RST_VAL(1'b1)
	) u_wait_sync (
		.clk(clk),
		.rst_n(rst_n_q),
		.d(ext_wait_n),
		.q(wait_pin)
	);

	datc_phase_timer #(
		.CNT_W(CNT_W_TOP)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n_q),
		.load(tmr_load),
		.load_val(tmr_val),
		.wait_en(wait_en_q),
		.wait_act(!wait_pin),
		.last(tmr_last)
	);

	// Request in hand: fresh at dispatch, the captured one afterwards
	assign dreq = (state_q == datc_pkg::ST_IDLE) ? req : cur_q;
	assign dreq_row = dreq.addr >> shift_q;
	assign same_row = (dreq_row == open_row_q);
	assign keep_row = row_strobe_hold || burst_page_enable;

	// DMA DRAM code overrides the read and write codes
	assign col_code = dreq.dma ? dma_dram_wait :
		(dreq.write ? write_column_wait : read_column_wait);
	assign cs_wait = dreq.dma ? dma_cs_wait : cs_area_wait;

	assign col_len = datc_pkg::COL_HALF + {3'h0, col_code, 1'b0};
	assign cs_len = datc_pkg::CS_HALF + {1'b0, cs_wait, 1'b0};
	assign row_len = datc_pkg::ROW_HALF + {4'h0, row_to_column_delay, 1'b0};
	assign prechg_len = datc_pkg::PRECHG_HALF + {4'h0, precharge_length, 1'b0};
	assign refresh_enable_len = datc_pkg::REFRESH_ENABLE_HALF + {3'h0, refresh_assert_len, 1'b0};

	always_comb begin
		state_d = state_q;
		tmr_load = 1'b0;
		tmr_val = '0;
		wait_en_d = 1'b0;
		take = 1'b0;
		row_open_d = row_open_q;
		case (state_q)
			datc_pkg::ST_IDLE: begin
				// Requester drops valid after acc_done; skip its stale copy
				if (acc_done_q) begin
					state_d = state_q;
				end else if (refresh_enable_pend_q) begin
					tmr_load = 1'b1;
					if (row_open_q) begin
						state_d = datc_pkg::ST_PRECHG;
						tmr_val = prechg_len;
						row_open_d = 1'b0;
					end else begin
						state_d = datc_pkg::ST_CBR_CAS;
						tmr_val = datc_pkg::CBR_LEAD_HALF;
					end
				end else if (req_valid) begin
					tmr_load = 1'b1;
					if (gap_armed_q && idle_insert && (req.cs_space || req.write)) begin
						state_d = datc_pkg::ST_GAP;
						tmr_val = datc_pkg::GAP_HALF;
					end else if (row_open_q && (req.cs_space || !same_row)) begin
						state_d = datc_pkg::ST_PRECHG;
						tmr_val = prechg_len;
						row_open_d = 1'b0;
					end else if (req.cs_space) begin
						state_d = datc_pkg::ST_CS;
						tmr_val = cs_len;
						wait_en_d = (cs_wait != 4'h0);
						take = 1'b1;
					end else if (row_open_q) begin
						state_d = datc_pkg::ST_COL;
						tmr_val = col_len;
						wait_en_d = col_code[1];
						take = 1'b1;
					end else begin
						state_d = datc_pkg::ST_ROW;
						tmr_val = row_len;
						take = 1'b1;
					end
				end else if (row_open_q && !row_strobe_hold) begin
					// Page mode alone closes the row once the stream stops
					state_d = datc_pkg::ST_PRECHG;
					tmr_load = 1'b1;
					tmr_val = prechg_len;
					row_open_d = 1'b0;
				end
			end
			datc_pkg::ST_ROW: begin
				if (tmr_last) begin
					state_d = datc_pkg::ST_COL;
					tmr_load = 1'b1;
					tmr_val = col_len;
					wait_en_d = col_code[1];
				end
			end
			datc_pkg::ST_COL: begin
				if (tmr_last) begin
					if (keep_row) begin
						state_d = datc_pkg::ST_IDLE;
						row_open_d = 1'b1;
					end else begin
						state_d = datc_pkg::ST_PRECHG;
						tmr_load = 1'b1;
						tmr_val = prechg_len;
						row_open_d = 1'b0;
					end
				end
			end
			datc_pkg::ST_CS, datc_pkg::ST_GAP, datc_pkg::ST_PRECHG: begin
				if (tmr_last) begin
					state_d = datc_pkg::ST_IDLE;
				end
			end
			datc_pkg::ST_CBR_CAS: begin
				if (tmr_last) begin
					state_d = datc_pkg::ST_CBR_RAS;
					tmr_load = 1'b1;
					tmr_val = refresh_enable_len;
				end
			end
			datc_pkg::ST_CBR_RAS: begin
				if (tmr_last) begin
					state_d = datc_pkg::ST_PRECHG;
					tmr_load = 1'b1;
					tmr_val = prechg_len;
				end
			end
			default: begin
				state_d = datc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= datc_pkg::ST_IDLE;
			row_open_q <= 1'b0;
			wait_en_q <= 1'b0;
		end else begin
			state_q <= state_d;
			row_open_q <= row_open_d;
			if (tmr_load) begin
				wait_en_q <= wait_en_d;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cur_q <= '0;
			open_row_q <= 32'h0000_0000;
		end else if (take) begin
			cur_q <= req;
			if (!req.cs_space && !row_open_q) begin
				open_row_q <= dreq_row;
			end
		end
	end

	// Access completion and the read-then-write gap marker
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			acc_done_q <= 1'b0;
			gap_armed_q <= 1'b0;
		end else begin
			acc_done_q <= tmr_last &&
				(state_q == datc_pkg::ST_COL || state_q == datc_pkg::ST_CS);
			if (tmr_last && state_q == datc_pkg::ST_COL) begin
				gap_armed_q <= !cur_q.write;
			end else if (tmr_last &&
				(state_q == datc_pkg::ST_CS || state_q == datc_pkg::ST_GAP)) begin
				gap_armed_q <= 1'b0;
			end
		end
	end

	// A new match while one is pending merges with it; set wins over clear
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			refresh_enable_pend_q <= 1'b0;
		end else if (refresh_match && refresh_enable && !refresh_kind_select) begin
			refresh_enable_pend_q <= 1'b1;
		end else if (state_d == datc_pkg::ST_CBR_CAS) begin
			refresh_enable_pend_q <= 1'b0;
		end
	end

	// Pins follow the next state so each output is a plain flip-flop
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pins_q <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cs_n: 1'b1, addr: 16'h0000};
		end else begin
			pins_q.ras_n <= !(state_d == datc_pkg::ST_ROW || state_d == datc_pkg::ST_COL ||
				state_d == datc_pkg::ST_CBR_RAS ||
				(state_d == datc_pkg::ST_IDLE && row_open_d));
			pins_q.cas_n <= !(state_d == datc_pkg::ST_COL ||
				state_d == datc_pkg::ST_CBR_CAS || state_d == datc_pkg::ST_CBR_RAS);
			pins_q.we_n <= !((state_d == datc_pkg::ST_COL || state_d == datc_pkg::ST_CS) &&
				dreq.write);
			pins_q.cs_n <= !(state_d == datc_pkg::ST_CS);
			if (state_d == datc_pkg::ST_ROW) begin
				pins_q.addr <= dreq_row[15:0];
			end else if (state_d == datc_pkg::ST_COL || state_d == datc_pkg::ST_CS) begin
				pins_q.addr <= dreq.addr[15:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			width_q <= datc_pkg::WIDTH_8;
			shift_q <= datc_pkg::ROW_SHIFT_BASE;
		end else begin
			width_q <= dram_width[1] ? datc_pkg::WIDTH_32 :
				(dram_width[0] ? datc_pkg::WIDTH_16 : datc_pkg::WIDTH_8);
			shift_q <= datc_pkg::ROW_SHIFT_BASE + {2'h0, addr_multiplex};
		end
	end

	assign status = {8'h00, 1'b0, gap_armed_q, !wait_pin, refresh_enable_pend_q, row_open_q,
		state_q};

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign acc_done = acc_done_q;
	assign dram_pins = pins_q;
	assign bus_width = width_q;
	assign row_shift = shift_q;
endmodule

// ---- dv/datc_top_asserts.sv ----
// Port-level timing checks for the DRAM access timing block.
// Assumes it is bound to datc_top and sees only its ports.
`timescale 1ns/1ps
module datc_top_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Access, pins and decoded configuration
	input wire datc_pkg::datc_req_t req,
	input wire logic acc_done,
	input wire datc_pkg::datc_pins_t dram_pins,
	input wire logic [1:0] bus_width,
	input wire logic [3:0] row_shift
);
	logic [15:0] ctl_q;
	logic [5:0] low_q;
	logic cbr_q;
	logic ctl_wr;
	assign ctl_wr = psel && penable && pready && pwrite && paddr == datc_pkg::ADDR_DRAM_CTRL;
	// Shadow of the control register so checks follow live settings
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_q <= 16'h0000;
		end else if (ctl_wr) begin
			ctl_q <= pwdata[15:0] & datc_pkg::MASK_DRAM_CTRL;
		end
	end
	// Row strobe low run, flagged when it began under a low column strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_q <= 6'h00;
			cbr_q <= 1'b0;
		end else begin
			low_q <= dram_pins.ras_n ? 6'h00 : low_q + 6'h01;
			cbr_q <= !dram_pins.ras_n && (cbr_q || (low_q == 6'h00 && !dram_pins.cas_n));
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	reserved_zero_a: assert property (
		pready && !pwrite |-> prdata[31:16] == 16'h0000
		&& (paddr != datc_pkg::ADDR_DMA_WAIT || prdata[15:6] == 10'h000)
		&& (paddr != datc_pkg::ADDR_DRAM_CTRL || !prdata[6])) else $error("reserved bit set");
	width_map_a: assert property (ctl_wr |-> ##[1:2] bus_width == (ctl_q[3] ?
		datc_pkg::WIDTH_32 : (ctl_q[2] ? datc_pkg::WIDTH_16 : datc_pkg::WIDTH_8)))
		else $error("bus width decode wrong");
	shift_map_a: assert property (ctl_wr |-> ##[1:2]
		row_shift == datc_pkg::ROW_SHIFT_BASE + {2'b00, ctl_q[1:0]}) else $error("row shift wrong");
	precharge_min_a: assert property ($rose(dram_pins.ras_n) |-> dram_pins.ras_n[*3])
		else $error("precharge too short");
	precharge_long_a: assert property ($rose(dram_pins.ras_n) && ctl_q[15] |->
		dram_pins.ras_n[*5]) else $error("long precharge too short");
	row_delay_a: assert property ($fell(dram_pins.ras_n) && dram_pins.cas_n && !ctl_q[14]
		|-> dram_pins.cas_n[*2] ##1 !dram_pins.cas_n) else $error("row phase length wrong");
	read_col_a: assert property ($fell(dram_pins.cas_n) && !dram_pins.ras_n
		&& dram_pins.we_n && !req.dma && ctl_q[9:8] == 2'b00
		|-> !dram_pins.cas_n[*4] ##1 dram_pins.cas_n) else $error("read column length wrong");
	refresh_enable_len_a: assert property ($rose(dram_pins.ras_n) && cbr_q |->
		low_q == 6'h05 + {3'b000, ctl_q[13:12], 1'b0}) else $error("refresh length wrong");
	done_pulse_a: assert property (acc_done |=> !acc_done) else $error("acc_done too long");
endmodule

bind datc_top datc_top_asserts u_asserts (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .req, .acc_done, .dram_pins, .bus_width, .row_shift);

// ---- dv/datc_mem_model.sv ----
// Behavioural DRAM and chip-select memory at the pin side.
// Assumes registered pins; pulls the wait line low only when told to.
`timescale 1ns/1ps
module datc_mem_model (
	// Clock
	input wire logic clk,
	// Pins and wait command
	input wire datc_pkg::datc_pins_t pins,
	input wire logic [3:0] hold_wait,
	output logic ext_wait_n,
	// Measured strobe runs in clocks and a count of RAS falls
	output int col_len,
	output int row_len,
	output int refresh_enable_len,
	output int cs_len,
	output int ras_falls
);
	datc_pkg::datc_pins_t prev_q = '1;
	int cas_run = 0, row_run = 0, ras_run = 0, cs_run = 0;
	logic [3:0] wait_q = 4'h0;
	logic cbr_q = 1'b0;
	assign ext_wait_n = wait_q == 4'h0;
	initial begin
		{col_len, row_len, refresh_enable_len, cs_len, ras_falls} = '0;
	end
	always @(posedge clk) begin
		prev_q <= pins;
		cas_run <= pins.cas_n ? 0 : cas_run + 1;
		row_run <= (pins.ras_n || !pins.cas_n) ? 0 : row_run + 1;
		ras_run <= pins.ras_n ? 0 : ras_run + 1;
		cs_run <= pins.cs_n ? 0 : cs_run + 1;
		if (!pins.ras_n && prev_q.ras_n) begin
			ras_falls <= ras_falls + 1;
			cbr_q <= !pins.cas_n;
		end
		if (pins.cas_n && !prev_q.cas_n && !cbr_q) col_len <= cas_run;
		if (!pins.cas_n && prev_q.cas_n && !pins.ras_n) row_len <= row_run;
		if (pins.ras_n && !prev_q.ras_n && cbr_q) refresh_enable_len <= ras_run;
		if (pins.cs_n && !prev_q.cs_n) cs_len <= cs_run;
		// Slow device: wait held for the commanded clocks after a strobe falls
		if ((!pins.cas_n && prev_q.cas_n) || (!pins.cs_n && prev_q.cs_n)) begin
			wait_q <= hold_wait;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end
	end
endmodule

// ---- dv/datc_top_bench.sv ----
// Self-checking bench for the DRAM access timing block.
// Assumes the memory model measures strobe runs; this module is the APB master.
`timescale 1ns/1ps
module datc_top_bench;
	logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, acc_done, ext_wait_n, req_valid = 1'b0;
	datc_pkg::datc_req_t req = '0;
	logic [3:0] cs_area_wait = 4'h0, hold_wait = 4'h0, row_shift;
	logic refresh_match = 1'b0, refresh_enable = 1'b0, refresh_kind_select = 1'b0;
	datc_pkg::datc_pins_t dram_pins;
	logic [1:0] bus_width;
	int col_len, row_len, refresh_enable_len, cs_len, ras_falls;
	int num_errors = 0, n_checks = 0, cycles = 0, lat;
	localparam logic [31:0] A = 32'h0000_1000;
	localparam logic [7:0] CTL = datc_pkg::ADDR_DRAM_CTRL, DW = datc_pkg::ADDR_DMA_WAIT;
	always #2 clk = ~clk;
	datc_top DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .req_valid, .req, .cs_area_wait, .acc_done, .refresh_match, .refresh_enable,
		.refresh_kind_select, .ext_wait_n, .dram_pins, .bus_width, .row_shift);
	datc_mem_model u_mem (.clk, .pins(dram_pins), .hold_wait, .ext_wait_n, .col_len, .row_len,
		.refresh_enable_len, .cs_len, .ras_falls);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) num_errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0000_0000, rd, er);
		check(what, rd, exp);
	endtask
	// Keep leaves the request up; the next call swaps it at once, so no stale copy is taken
	task automatic access(input logic w, input logic dma, input logic cs, input bit keep = 1'b0);
		int n = 0;
		if (!req_valid) @(posedge clk);
		req_valid <= 1'b1;
		req <= {w, dma, cs, A};
		do begin
			@(posedge clk);
			n++;
		end while (acc_done !== 1'b1 && n < 200);
		lat = n;
		check("acc_done", acc_done, 1'b1);
		if (!keep) begin
			req_valid <= 1'b0;
			repeat (12) @(posedge clk);
		end
	endtask

	task automatic t_regs();
		logic [31:0] rd;
		logic er;
		rd_chk("wait reset", DW, 32'h0000_000f);
		rd_chk("ctrl reset", CTL, 32'h0000_0000);
		wr(DW, 32'hffff_ffff);
		rd_chk("wait mask", DW, 32'h0000_003f);
		wr(CTL, 32'hffff_ffff);
		rd_chk("ctrl mask", CTL, 32'h0000_ffbf);
		apb(1'b0, 8'h0c, 32'h0000_0000, rd, er);
		check("unmapped err", er, 1'b1);
		check("unmapped data", rd, 32'h0000_0000);
		for (int c = 0; c < 4; c++) begin
			wr(CTL, (c << datc_pkg::POS_WIDTH) | c);
			repeat (2) @(posedge clk);
			check("bus width", bus_width, c[1] ? 2 : c[0]);
			check("row shift", row_shift, 9 + c);
		end
		$display("test regs done");
	endtask
	task automatic t_cols();
		for (int c = 0; c < 4; c++) begin
			// Control settled before any DRAM access
			wr(CTL, (c << datc_pkg::POS_READ_WAIT) | ((3 - c) <<
				datc_pkg::POS_WRITE_WAIT) | (c[0] << datc_pkg::POS_ROW_TO_COL) |
				(c[1] << datc_pkg::POS_PRECHARGE));
			wr(DW, (c ^ 1) << datc_pkg::POS_DMA_DRAM_WAIT);
			access(1'b0, 1'b0, 1'b0);
			check("read col", col_len, 4 + 2 * c);
			check("row len", row_len, c[0] ? 4 : 2);
			access(1'b1, 1'b0, 1'b0);
			check("write col", col_len, 4 + 2 * (3 - c));
			access(1'b0, 1'b1, 1'b0);
			check("dma col", col_len, 4 + 2 * (c ^ 1));
		end
		$display("test columns done");
	endtask
	task automatic t_wait();
		hold_wait <= 4'hc;
		wr(CTL, 32'h0000_0000);
		access(1'b0, 1'b0, 1'b0);
		check("read no wait", col_len, 4);
		wr(CTL, 2 << datc_pkg::POS_READ_WAIT);
		access(1'b0, 1'b0, 1'b0);
		check("read wait", col_len > 8, 1'b1);
		wr(DW, 32'h0000_0010);
		access(1'b0, 1'b1, 1'b0);
		check("dma no wait", col_len, 6);
		wr(DW, 32'h0000_0020);
		access(1'b0, 1'b1, 1'b0);
		check("dma wait", col_len > 8, 1'b1);
		access(1'b0, 1'b1, 1'b1);
		check("cs wait off", cs_len, 4);
		wr(DW, 32'h0000_0001);
		access(1'b0, 1'b1, 1'b1);
		check("cs wait on", cs_len > 6, 1'b1);
		hold_wait <= 4'h0;
		cs_area_wait <= 4'h5;
		wr(DW, 32'h0000_000f);
		access(1'b0, 1'b1, 1'b1);
		check("cs wait max", cs_len, 34);
		access(1'b1, 1'b0, 1'b1);
		check("cs area wait", cs_len, 14);
		cs_area_wait <= 4'h0;
		$display("test waits done");
	endtask
	task automatic t_refresh_enable();
		int n;
		refresh_enable <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			refresh_kind_select <= k == 2;
			wr(CTL, (k * 3) << datc_pkg::POS_REFRESH_LEN);
			n = ras_falls;
			refresh_match <= 1'b1;
			@(posedge clk);
			refresh_match <= 1'b0;
			repeat (40) @(posedge clk);
			if (k < 2) check("refresh len", refresh_enable_len, 5 + 6 * k);
			else check("self refresh", ras_falls - n, 0);
		end
		refresh_enable <= 1'b0;
		refresh_kind_select <= 1'b0;
		$display("test refresh done");
	endtask
	task automatic t_modes();
		int a, n;
		for (int g = 0; g < 2; g++) begin
			wr(CTL, g << datc_pkg::POS_IDLE_INSERT);
			access(1'b0, 1'b0, 1'b0);
			access(1'b1, 1'b0, 1'b0);
			if (g == 0) a = lat;
		end
		// Two-clock idle cycle plus one clock back through idle
		check("idle insert", lat, a + 3);
		wr(CTL, 1 << datc_pkg::POS_BURST_PAGE);
		n = ras_falls;
		access(1'b0, 1'b0, 1'b0, 1'b1);
		access(1'b0, 1'b0, 1'b0);
		check("page row reuse", ras_falls - n, 1);
		wr(CTL, 32'h0000_0000);
		access(1'b0, 1'b0, 1'b0);
		check("ras up", dram_pins.ras_n, 1'b1);
		wr(CTL, 1 << datc_pkg::POS_ROW_HOLD);
		access(1'b0, 1'b0, 1'b0);
		check("ras down", dram_pins.ras_n, 1'b0);
		access(1'b0, 1'b0, 1'b1);
		check("ras down release", dram_pins.ras_n, 1'b1);
		$display("test modes done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole run needs well under two thousand clocks
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_cols();
		t_wait();
		t_refresh_enable();
		t_modes();
		complete_run();
	end
endmodule
